// [core/rom_patch_pkg.sv]
// Constants shared by the ROM patch unit and its entry matcher.
// Assumes a 32-bit AHB-Lite bus with word-sized patch entries.
package rom_patch_pkg;

  // Entry count and word width
  localparam int NUM_ENTRIES = 8;
  localparam int WORD_W = 32;
  localparam int IDX_W = 3;

  // Register window base 0x40008400, 1 KiB long
  localparam logic [21:0] WIN_TAG = 22'h100021;
  localparam int WIN_LSB = 10;

  // Word offsets (byte offset / 4) inside the window
  localparam logic [7:0] OFS_ENTRY_LIMIT = 8'h10;
  localparam logic [7:0] OFS_VALID = 8'h10;
  localparam logic [7:0] OFS_DISABLE = 8'h11;
  localparam logic [7:0] OFS_ENABLE = 8'h12;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// [core/patch_match.sv]
// Parallel address comparators and priority multiplexer for patch entries.
// Assumes stored addresses and valid flags come from registers on the same clock.
`timescale 1ns/10ps

module patch_match (
  // Bus address under test
  input wire logic [31:0] i_addr,
  // Entry storage
  input wire logic [7:0][31:0] i_match_addr,
  input wire logic [7:0][31:0] i_replace_word,
  input wire logic [7:0] i_valid,
  // Result
  output logic [7:0] o_match,
  output logic o_hit,
  output logic [2:0] o_hit_idx,
  output logic [31:0] o_word
);

  // [RULE6] eight parallel comparators
  always_comb begin
    for (int i = 0; i < rom_patch_pkg::NUM_ENTRIES; i++) begin
      o_match[i] = (i_addr[31:2] == i_match_addr[i][31:2]);
    end
  end

  // [RULE8] highest index wins
  always_comb begin
    o_hit = 1'b0;
    o_hit_idx = 3'h0;
    o_word = rom_patch_pkg::RST_WORD;
    for (int i = 0; i < rom_patch_pkg::NUM_ENTRIES; i++) begin
      if (o_match[i] && i_valid[i]) begin
        o_hit = 1'b1;
        o_hit_idx = 3'(i);
        o_word = i_replace_word[i];
      end
    end
  end

endmodule

// [core/rom_patch_unit.sv]
// ROM patch unit: AHB-Lite register slave plus substitution on ROM read data.
// Assumes the ROM controller returns read data with a valid strobe in the
// data phase of the access whose address phase the unit saw on the bus.
`timescale 1ns/10ps

// Function
// [RULE1] All configuration registers are read and written as an AHB-Lite slave; the valid register ignores writes, disable and enable read zero.
// [RULE2] The unit runs on the bus clock and holds nothing over reset, so software reloads it.
// [RULE3] Eight entries each pair a match address word with a replacement word at adjacent offsets.
// [RULE4] Software writes an entry's address before its replacement word.
// [RULE5] Writing the replacement word after the address sets that entry's valid flag by itself.
// [RULE6] The bus address is compared against all eight entries at once.
// [RULE7] A valid matching entry supplies its word in place of the ROM data.
// [RULE8] Among several valid matches the highest entry index wins.
// [RULE9] A one in the disable register clears the valid flag of that entry only.
// [RULE10] A one in the enable register sets the valid flag of that entry again.
// [RULE11] Substitution is a multiplexer between ROM data and the stored word.
// [RULE12] The registers are decoded in the window 0x40008400 to 0x400087ff.
// [RULE13] Software picks a free entry and weighs priority before programming a pair.
// [RULE14] Without a valid match the ROM data passes through unchanged.
module rom_patch_unit (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // ROM controller read data path
  input wire logic [31:0] i_rom_rdata,
  input wire logic i_rom_rvalid,
  output logic [31:0] o_rom_rdata,
  output logic o_rom_rvalid,
  output logic o_patch_hit
);

  // Byte lanes of a write from its size and low address bits
  function automatic logic [3:0] byte_mask(input logic [2:0] size, input logic [1:0] lo);
    logic [3:0] m;
    m = 4'hf;
    if (size == rom_patch_pkg::HSIZE_BYTE) begin
      m = 4'(4'h1 << lo);
    end else if (size == rom_patch_pkg::HSIZE_HALF) begin
      m = lo[1] ? 4'hc : 4'h3;
    end
    return m;
  endfunction

  // Merge write data into an old word under a lane mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (m[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Storage
  logic [7:0][31:0] match_addr_ff;
  logic [7:0][31:0] replace_word_ff;
  logic [7:0] valid_ff;
  logic [7:0] addr_seen_ff;
  logic [7:0] nxt_valid;

  // Bus phase tracking
  logic wr_pend_ff;
  logic [7:0] wr_ofs_ff;
  logic [3:0] wr_mask_ff;
  logic rd_pend_ff;
  logic rd_inwin_ff;
  logic [7:0] rd_ofs_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;

  // Patch path
  logic hit_ff;
  logic [2:0] hit_idx_ff;
  logic [31:0] word_ff;
  logic [31:0] rom_rdata_ff;
  logic rom_rvalid_ff;
  logic patch_hit_ff;

  // Matcher results
  logic [7:0] match_vec;
  logic lookup_hit;
  logic [2:0] lookup_idx;
  logic [31:0] lookup_word;

  // Address phase decode
  logic bus_req;
  logic in_win;
  logic reg_req;
  logic lookup;
  assign bus_req = i_hsel && i_hready && i_htrans[1];
  // [RULE12] window decode on upper address bits
  assign in_win = (i_haddr[31:rom_patch_pkg::WIN_LSB] == rom_patch_pkg::WIN_TAG);
  assign reg_req = bus_req && in_win;
  assign lookup = i_hready && i_htrans[1] && !i_hwrite;

  // Committed write decode
  logic wr_entry;
  logic [2:0] wr_idx;
  logic wr_is_data;
  logic data_commit;
  logic addr_commit;
  logic dis_commit;
  logic ena_commit;
  assign wr_entry = wr_ofs_ff < rom_patch_pkg::OFS_ENTRY_LIMIT;
  assign wr_idx = wr_ofs_ff[3:1];
  assign wr_is_data = wr_ofs_ff[0];
  assign data_commit = wr_pend_ff && wr_entry && wr_is_data;
  assign addr_commit = wr_pend_ff && wr_entry && !wr_is_data;
  assign dis_commit = wr_pend_ff && (wr_ofs_ff == rom_patch_pkg::OFS_DISABLE);
  assign ena_commit = wr_pend_ff && (wr_ofs_ff == rom_patch_pkg::OFS_ENABLE);

  // [RULE1] capture write address phase
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff <= 8'h00;
      wr_mask_ff <= 4'h0;
    end else begin
      wr_pend_ff <= reg_req && i_hwrite;
      wr_ofs_ff <= i_haddr[9:2];
      wr_mask_ff <= byte_mask(i_hsize, i_haddr[1:0]);
    end
  end

  // [RULE3] entry address and word storage
  // [RULE2] cleared by every reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      match_addr_ff <= '0;
      replace_word_ff <= '0;
    end else if (addr_commit) begin
      match_addr_ff[wr_idx] <= merge(match_addr_ff[wr_idx], i_hwdata, wr_mask_ff);
    end else if (data_commit) begin
      replace_word_ff[wr_idx] <= merge(replace_word_ff[wr_idx], i_hwdata, wr_mask_ff);
    end
  end

  // Address written since last pairing
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      addr_seen_ff <= rom_patch_pkg::RST_FLAGS;
    end else if (addr_commit) begin
      addr_seen_ff[wr_idx] <= 1'b1;
    end else if (data_commit) begin
      addr_seen_ff[wr_idx] <= 1'b0;
    end
  end

  // Valid flag next value
  always_comb begin
    nxt_valid = valid_ff;
    // [RULE9] disable strobe clears flagged entries
    if (dis_commit) begin
      nxt_valid = valid_ff & ~i_hwdata[7:0];
    end
    // [RULE10] enable strobe sets flagged entries
    if (ena_commit) begin
      nxt_valid = valid_ff | i_hwdata[7:0];
    end
    // [RULE5] auto set on completed pair
    if (data_commit && addr_seen_ff[wr_idx]) begin
      nxt_valid[wr_idx] = 1'b1;
    end
  end

  // Valid flags
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      valid_ff <= rom_patch_pkg::RST_FLAGS;
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  // Read address phase, one wait state
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rd_pend_ff <= 1'b0;
      rd_inwin_ff <= 1'b0;
      rd_ofs_ff <= 8'h00;
    end else begin
      rd_pend_ff <= bus_req && !i_hwrite;
      rd_inwin_ff <= in_win;
      rd_ofs_ff <= i_haddr[9:2];
    end
  end

  // [RULE1] read data and ready
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hrdata_ff <= rom_patch_pkg::RST_WORD;
      hreadyout_ff <= 1'b1;
      hresp_ff <= rom_patch_pkg::HRESP_OKAY;
    end else begin
      hresp_ff <= rom_patch_pkg::HRESP_OKAY;
      hreadyout_ff <= !(bus_req && !i_hwrite);
      if (rd_pend_ff) begin
        hrdata_ff <= rom_patch_pkg::RST_WORD;
        if (rd_inwin_ff && rd_ofs_ff < rom_patch_pkg::OFS_ENTRY_LIMIT) begin
          hrdata_ff <= rd_ofs_ff[0] ? replace_word_ff[rd_ofs_ff[3:1]]
                                    : match_addr_ff[rd_ofs_ff[3:1]];
        end else if (rd_inwin_ff && rd_ofs_ff == rom_patch_pkg::OFS_VALID) begin
          hrdata_ff <= {24'h000000, valid_ff};
        end
      end
    end
  end

  // Entry matcher
  patch_match u_match (
    .i_addr(i_haddr),
    .i_match_addr(match_addr_ff),
    .i_replace_word(replace_word_ff),
    .i_valid(valid_ff),
    .o_match(match_vec),
    .o_hit(lookup_hit),
    .o_hit_idx(lookup_idx),
    .o_word(lookup_word)
  );

  // [RULE6] hold lookup result for the data phase
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hit_ff <= 1'b0;
      hit_idx_ff <= 3'h0;
      word_ff <= rom_patch_pkg::RST_WORD;
    end else if (lookup) begin
      hit_ff <= lookup_hit;
      hit_idx_ff <= lookup_idx;
      word_ff <= lookup_word;
    end
  end

  // [RULE11] data bus multiplexer
  // [RULE7] [RULE14] patched or passed word
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rom_rdata_ff <= rom_patch_pkg::RST_WORD;
      rom_rvalid_ff <= 1'b0;
      patch_hit_ff <= 1'b0;
    end else begin
      rom_rvalid_ff <= i_rom_rvalid;
      patch_hit_ff <= i_rom_rvalid && hit_ff;
      if (i_rom_rvalid) begin
        rom_rdata_ff <= hit_ff ? word_ff : i_rom_rdata;
      end
    end
  end

  // Outputs
  assign o_hrdata = hrdata_ff;
  assign o_hreadyout = hreadyout_ff;
  assign o_hresp = hresp_ff;
  assign o_rom_rdata = rom_rdata_ff;
  assign o_rom_rvalid = rom_rvalid_ff;
  assign o_patch_hit = patch_hit_ff;

  // Read takes one wait state then completes
  chk_read_wait_state: assert property ( // [RULE1]
    @(posedge i_clock) disable iff (i_sys_rst)
    (bus_req && !i_hwrite) |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");

  // Full address write lands in the entry
  chk_addr_stored: assert property ( // [RULE3]
    @(posedge i_clock) disable iff (i_sys_rst)
    (addr_commit && wr_mask_ff == 4'hf) |=> match_addr_ff[$past(wr_idx)] == $past(i_hwdata))
    else $error("match address not stored");

  // Pair completion sets valid
  chk_valid_auto_set: assert property ( // [RULE5]
    @(posedge i_clock) disable iff (i_sys_rst)
    (data_commit && addr_seen_ff[wr_idx]) |=> valid_ff[$past(wr_idx)])
    else $error("valid not set after pair");

  // Disable clears flagged bits
  chk_disable_clears: assert property ( // [RULE9]
    @(posedge i_clock) disable iff (i_sys_rst)
    dis_commit |=> ((valid_ff & $past(i_hwdata[7:0])) == 8'h00)
      && ((valid_ff & ~$past(i_hwdata[7:0])) == ($past(valid_ff) & ~$past(i_hwdata[7:0]))))
    else $error("disable strobe wrong");

  // Enable sets flagged bits
  chk_enable_sets: assert property ( // [RULE10]
    @(posedge i_clock) disable iff (i_sys_rst)
    ena_commit |=> ((valid_ff & $past(i_hwdata[7:0])) == $past(i_hwdata[7:0])))
    else $error("enable strobe wrong");

  // Patched word replaces ROM data
  chk_patch_word: assert property ( // [RULE7]
    @(posedge i_clock) disable iff (i_sys_rst)
    (i_rom_rvalid && hit_ff) |=> o_rom_rvalid && o_patch_hit && o_rom_rdata == $past(word_ff))
    else $error("patch word not driven");

  // ROM data passes without a hit
  chk_rom_pass: assert property ( // [RULE14]
    @(posedge i_clock) disable iff (i_sys_rst)
    (i_rom_rvalid && !hit_ff) |=> !o_patch_hit && o_rom_rdata == $past(i_rom_rdata))
    else $error("rom data altered");

  // Top valid match wins
  chk_top_entry_wins: assert property ( // [RULE8]
    @(posedge i_clock) disable iff (i_sys_rst)
    (lookup && match_vec[7] && valid_ff[7]) |=> hit_ff && hit_idx_ff == 3'h7)
    else $error("priority order wrong");

  // Reads outside the window return zero
  chk_window_decode: assert property ( // [RULE12]
    @(posedge i_clock) disable iff (i_sys_rst)
    (bus_req && !i_hwrite && !in_win) |-> ##2 o_hrdata == 32'h00000000)
    else $error("outside window read nonzero");

endmodule

// [test/rom_model.sv]
// ROM controller stand-in: answers each bus read below 0x40000000.
// Assumes a zero-wait data phase and the unit's own clock.
`timescale 1ns/10ps

module rom_model #(
  parameter logic [31:0] KEY = 32'ha5a5_0f0f
) (
  // Bus side
  input wire logic i_clock,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  // Data path
  output logic [31:0] o_rdata,
  output logic o_rvalid
);

  // Word in the data phase, inverted junk outside it
  always @(posedge i_clock) begin : answer
    logic hit;
    logic [31:0] a;
    hit = i_hready & i_htrans[1] & ~i_hwrite & (i_haddr[31:30] == 2'h0);
    a = i_haddr;
    #1;
    o_rvalid = hit;
    o_rdata = hit ? ({a[31:2], 2'h0} ^ KEY) : ~o_rdata;
  end
endmodule

// [test/tb_rom_patch_unit.sv]
// Testbench for the ROM patch unit: bus tasks, reference model, monitor.
// Assumes one bus master and rom_model on the ROM data path.
`timescale 1ns/10ps

module tb_rom_patch_unit;
  localparam logic [31:0] KEY = 32'ha5a5_0f0f;
  localparam logic [31:0] BASE = 32'h4000_8400;
  logic i_clock, i_sys_rst, i_hsel, i_hwrite, i_hready, i_rom_rvalid;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  logic [2:0] sz;
  logic [31:0] i_haddr, i_hwdata, i_rom_rdata, o_hrdata, o_rom_rdata, seed;
  logic o_hreadyout, o_hresp, o_rom_rvalid, o_patch_hit, rd_ph;
  logic [31:0] ma [8];
  logic [31:0] rw [8];
  logic [7:0] vld;
  logic [7:0] dis [3] = '{8'h80, 8'h40, 8'h04};
  logic [32:0] q_rom [$];
  logic [32:0] q_reg [$];
  int n_fail, checked;

  assign i_hready = o_hreadyout;

  rom_patch_unit dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_rom_rdata(i_rom_rdata), .i_rom_rvalid(i_rom_rvalid),
    .o_rom_rdata(o_rom_rdata), .o_rom_rvalid(o_rom_rvalid), .o_patch_hit(o_patch_hit)
  );

  rom_model #(.KEY(KEY)) rom_side (
    .i_clock(i_clock), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .o_rdata(i_rom_rdata), .o_rvalid(i_rom_rvalid)
  );

  // Clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Highest valid matching entry, else the ROM word
  function automatic logic [32:0] expect_rom(input logic [31:0] a);
    logic [32:0] r;
    r = {1'b0, {a[31:2], 2'h0} ^ KEY};
    for (int i = 0; i < 8; i++) begin
      if (vld[i] && ma[i][31:2] == a[31:2]) r = {1'b1, rw[i]};
    end
    return r;
  endfunction

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One transfer: address phase, then wait out the data phase
  task automatic bus(input logic sel, input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clock);
    #1;
    i_hsel = sel;
    i_hwrite = wr;
    i_haddr = a;
    i_hsize = sz;
    i_htrans = 2'h2;
    @(posedge i_clock);
    #1;
    i_hsel = 1'b0;
    i_htrans = 2'h0;
    i_hwdata = d;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (!o_hreadyout && n < 8);
    if (!o_hreadyout) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    bus(1'b1, 1'b1, BASE + {24'h0, o}, d);
  endtask

  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    q_reg.push_back({rom_patch_pkg::HRESP_OKAY, e});
    bus(1'b1, 1'b0, BASE + {24'h0, o}, 32'h0);
  endtask

  task automatic rom(input logic [31:0] a);
    q_rom.push_back(expect_rom(a));
    bus(1'b0, 1'b0, a, 32'h0);
  endtask

  // Monitor takes the oldest note when a result shows
  always @(posedge i_clock) begin
    logic [32:0] note;
    note = 'x;
    if (o_rom_rvalid) begin
      note = (q_rom.size() > 0) ? q_rom.pop_front() : 'x;
      check("rom", {o_patch_hit, o_rom_rdata}, note);
    end
    if (rd_ph && o_hreadyout) begin
      note = (q_reg.size() > 0) ? q_reg.pop_front() : 'x;
      check("reg", {o_hresp, o_hrdata}, note);
    end
    // Read data phase tracker, dropped by reset
    if (i_sys_rst) begin
      rd_ph <= 1'b0;
    end else if (o_hreadyout) begin
      rd_ph <= i_hsel & i_htrans[1] & ~i_hwrite;
    end
  end

  // Main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    seed = 32'h0000_2e1c;
    {i_sys_rst, i_hsel, i_hwrite, i_htrans, vld} = {1'b1, 12'h0};
    {i_haddr, i_hwdata, i_hsize, sz} = {64'h0, 3'h2, 3'h2};
    repeat (4) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    rd(8'h40, 32'h0); // flags clear
    rom(32'h2000); // plain word
    // free entries in order, three share one address
    for (int x = 0; x < 8; x++) begin
      ma[x] = 32'h2000 + 32'((x < 6 ? x : 2) * 4);
      seed = rnd(seed);
      rw[x] = seed;
      wr(8'(8 * x), ma[x]); // address first
      rd(8'h40, {24'h0, vld}); // not valid yet
      wr(8'(8 * x + 4), rw[x]); // word second
      vld[x] = 1'b1;
      rd(8'h40, {24'h0, vld}); // flag set alone
      rd(8'(8 * x), ma[x]); // address readback
      rd(8'(8 * x + 4), rw[x]); // word readback
    end
    for (int x = 0; x < 7; x++) begin
      rom(32'h2000 + 32'(x * 4));
    end
    foreach (dis[i]) begin
      wr(8'h44, {24'h0, dis[i]}); // clear one flag
      vld = vld & ~dis[i];
      rd(8'h40, {24'h0, vld}); // others kept
      rom(32'h2008); // next entry wins, ROM word once entries 7, 6 and 2 are clear
    end
    wr(8'h48, 32'h80); // set flag again
    vld[7] = 1'b1;
    rom(32'h2008); // entry back
    sz = rom_patch_pkg::HSIZE_BYTE;
    wr(8'h05, 32'h0000_5a00); // byte lane one
    sz = rom_patch_pkg::HSIZE_HALF;
    wr(8'h06, 32'hc3c3_0000); // upper half
    sz = 3'h2;
    rw[0][31:8] = 24'hc3c35a;
    rd(8'h04, rw[0]); // lanes merged
    rom(32'h2000); // merged word used
    rd(8'h48, 32'h0); // strobe reads zero
    rd(8'h4c, 32'h0); // unmapped reads zero
    bus(1'b1, 1'b1, 32'h4000_8000, 32'hffff_ffff); // outside window
    rd(8'h00, ma[0]); // entry kept
    q_reg.push_back({rom_patch_pkg::HRESP_OKAY, 32'h0});
    bus(1'b1, 1'b0, 32'h4000_8800, 32'h0); // reads zero
    repeat (24) begin
      seed = rnd(seed);
      rom(32'h2000 + {26'h0, seed[3:0], 2'h0}); // random lookups
    end
    // Second reset in mid run drops every entry
    repeat (3) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b1;
    @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    vld = 8'h0;
    rd(8'h40, 32'h0); // flags lost
    rom(32'h2008); // no patch left
    repeat (4) @(posedge i_clock);
    check("pending", 33'(q_rom.size() + q_reg.size()), 33'h0); // all answered
    finish_test();
  end
endmodule
